// ===== ifc_pkg.sv
// Package with the constants, types and register map of the infeed on/off controller.
package ifc_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Timing: one program cycle is a fixed number of system clocks.
	localparam int unsigned CLK_PERIOD_NS   = 4;
	localparam int unsigned PROG_CYCLE_NS   = 1000;
	localparam logic [7:0]  PROG_CYCLE_CLKS = 8'(PROG_CYCLE_NS / CLK_PERIOD_NS);

	////////////////////////////////////////////////////////////////////////////////
	// Register byte offsets on the software port.
	localparam logic [7:0] REG_CTRL  = 8'h00;
	localparam logic [7:0] REG_ADDR  = 8'h04;
	localparam logic [7:0] REG_STAT  = 8'h08;
	localparam logic [7:0] REG_ERRC  = 8'h0c;
	localparam logic [7:0] REG_PRDS  = 8'h10;
	localparam logic [7:0] REG_WORDS = 8'h14;

	// Field positions in the control register and reset values.
	localparam int unsigned CTRL_EN_BIT   = 0;
	localparam int unsigned CTRL_RST_BIT  = 1;
	localparam int unsigned CTRL_TYPE_LSB = 4;
	localparam logic [31:0] CTRL_RESET    = 32'h0000_0000;
	localparam logic [31:0] ADDR_RESET    = 32'h0000_0000;

	// Edge detector lanes.
	localparam int unsigned EDGE_EN  = 0;
	localparam int unsigned EDGE_RST = 1;

	////////////////////////////////////////////////////////////////////////////////
	// Bits of the cyclic words exchanged with the infeed.
	localparam int unsigned CW_ON_BIT    = 0;
	localparam int unsigned CW_ACK_BIT   = 7;
	localparam int unsigned SW_READY_BIT = 0;
	localparam int unsigned SW_FAULT_BIT = 3;
	localparam logic [15:0] CW_RESET     = 16'h0000;

	// Error codes reported on the error code output.
	localparam logic [31:0] ERR_NONE         = 32'h0000_0000;
	localparam logic [31:0] ERR_NO_TYPE      = 32'h0000_c350;
	localparam logic [31:0] ERR_PRD          = 32'h0000_c351;
	localparam logic [31:0] ERR_INFEED_FAULT = 32'h0000_c352;

	// Parameter-read status values.
	localparam logic [31:0] PRD_IDLE     = 32'h0000_0000;
	localparam logic [31:0] PRD_REQ      = 32'h0000_7001;
	localparam logic [31:0] PRD_WAIT     = 32'h0000_7002;
	localparam logic [31:0] PRD_ERR_BASE = 32'hffff_8000;

	////////////////////////////////////////////////////////////////////////////////
	// Infeed type selector codes.
	typedef enum logic [2:0] {
		type_undefined = 3'h0,
		type_active    = 3'h1,
		type_smart     = 3'h2,
		type_basic     = 3'h3,
		type_auto      = 3'h4
	} ifc_type_t;

	// Controller states.
	typedef enum logic [1:0] {
		st_off    = 2'b00,
		st_detect = 2'b01,
		st_start  = 2'b10,
		st_on     = 2'b11
	} ifc_state_t;

	// Parameter-read function states.
	typedef enum logic [1:0] {
		prd_idle = 2'b00,
		prd_req  = 2'b01,
		prd_wait = 2'b10,
		prd_done = 2'b11
	} ifc_prd_state_t;

endpackage

// ===== ifc_edge.sv
// Rising edge detector sampled once per program cycle.
`timescale 1ns/1ns
module ifc_edge (
	// Clock and reset.
	input  wire logic       mclk_i,
	input  wire logic       resetn_i,
	// Program cycle tick and levels.
	input  wire logic       tick_i,
	input  wire logic [1:0] level_i,
	// Rise pulses, valid while tick_i is high.
	output logic      [1:0] rise_o
);

	logic [1:0] prev_q;
	logic [1:0] prev_d;

	////////////////////////////////////////////////////////////////////////////////
	// Each lane compares its level with the value from the previous program cycle.
	for (genvar g = 0; g < 2; g++) begin : g_lane
		always_comb begin
			prev_d[g] = tick_i ? level_i[g] : prev_q[g];
			rise_o[g] = tick_i & level_i[g] & ~prev_q[g];
		end
	end

	// Previous-cycle sample register.
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			prev_q <= 2'h0;
		end else begin
			prev_q <= prev_d;
		end
	end

endmodule

// ===== ifc_prd.sv
// Acyclic parameter read that detects the infeed type.
`timescale 1ns/1ns
module ifc_prd (
	// Clock and reset.
	input  wire logic        mclk_i,
	input  wire logic        resetn_i,
	// Controller side.
	input  wire logic        start_i,
	input  wire logic        abort_i,
	input  wire logic [31:0] addr_i,
	output logic             res_valid_o,
	output logic             res_ok_o,
	output logic      [1:0]  res_type_o,
	output logic      [31:0] status_o,
	// Parameter request channel.
	output logic             prd_req_o,
	output logic      [31:0] prd_addr_o,
	input  wire logic        prd_ack_i,
	input  wire logic        prd_ok_i,
	input  wire logic [1:0]  prd_type_i,
	input  wire logic [11:0] prd_fault_i
);

	ifc_pkg::ifc_prd_state_t st_q, st_d;
	logic        req_q, req_d;
	logic [31:0] addr_q, addr_d;
	logic        ok_q, ok_d;
	logic [1:0]  typ_q, typ_d;
	logic [31:0] stat_q, stat_d;

	////////////////////////////////////////////////////////////////////////////////
	// One request pulse, then wait for the answer and hold the result until restarted or aborted.
	always_comb begin
		st_d   = st_q;
		req_d  = 1'b0;
		addr_d = addr_q;
		ok_d   = ok_q;
		typ_d  = typ_q;
		stat_d = stat_q;
		if (abort_i) begin
			st_d   = ifc_pkg::prd_idle;
			stat_d = ifc_pkg::PRD_IDLE;
		end else if (start_i) begin
			st_d   = ifc_pkg::prd_req;
			req_d  = 1'b1;
			addr_d = addr_i;
			ok_d   = 1'b0;
			stat_d = ifc_pkg::PRD_REQ;
		end else begin
			unique case (st_q)
				ifc_pkg::prd_idle: begin
				end
				ifc_pkg::prd_req: begin
					st_d   = ifc_pkg::prd_wait;
					stat_d = ifc_pkg::PRD_WAIT;
				end
				ifc_pkg::prd_wait: begin
					if (prd_ack_i) begin
						st_d  = ifc_pkg::prd_done;
						typ_d = prd_type_i;
						if (prd_ok_i && prd_type_i != 2'h0) begin
							ok_d   = 1'b1;
							stat_d = ifc_pkg::PRD_IDLE;
						end else begin
							stat_d = ifc_pkg::PRD_ERR_BASE | {20'h0_0000, prd_fault_i};
						end
					end
				end
				ifc_pkg::prd_done: begin
				end
			endcase
		end
	end

	// State registers.
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			st_q   <= ifc_pkg::prd_idle;
			req_q  <= 1'b0;
			addr_q <= ifc_pkg::ADDR_RESET;
			ok_q   <= 1'b0;
			typ_q  <= 2'h0;
			stat_q <= ifc_pkg::PRD_IDLE;
		end else begin
			st_q   <= st_d;
			req_q  <= req_d;
			addr_q <= addr_d;
			ok_q   <= ok_d;
			typ_q  <= typ_d;
			stat_q <= stat_d;
		end
	end

	assign res_valid_o = (st_q == ifc_pkg::prd_done);
	assign res_ok_o    = ok_q;
	assign res_type_o  = typ_q;
	assign status_o    = stat_q;
	assign prd_req_o   = req_q;
	assign prd_addr_o  = addr_q;

endmodule

// ===== ifc_infeed_ctrl.sv
// Infeed on/off controller: register port, program-cycle sequencer and cyclic words.
//
// Behaviour
// - Enable rising resolves the infeed type from the selector, then commands switch-on.
// - Enable low commands the infeed off.
// - Only a rising reset acknowledges errors; a steady level does nothing.
// - The prepared control word is presented on the control output.
// - Selector codes: active 1, smart 2, basic 3; default undefined.
// - Selector value 4 picks automatic type detection.
// - Selector changes while switched on cause no reaction.
// - A new selector value is taken only at the next enable rise.
// - The logical address is used only for automatic detection.
// - Done pulses for one program cycle when a job completes cleanly.
// - Error goes true when request processing fails.
// - Error code carries the error information while error is true.
// - Parameter-read status reports the internal parameter-read function.
// - Activated is true exactly while the infeed is switched on.
// - With error true, an enable rise does not switch the infeed on.
// - Enable and reset rising together acknowledge first, then switch on.
// - Clean acknowledge clears error and code; a remaining fault updates the code.
`timescale 1ns/1ns
module ifc_infeed_ctrl (
	// Clock and reset.
	input  wire logic        mclk_i,
	input  wire logic        resetn_i,
	// Software register port.
	input  wire logic [7:0]  addr_i,
	input  wire logic [31:0] wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	output logic      [31:0] rdata_o,
	// Cyclic words exchanged with the infeed.
	input  wire logic [15:0] status_word_i,
	output logic      [15:0] control_word_out_o,
	// Result outputs.
	output logic             done_o,
	output logic             error_o,
	output logic      [31:0] error_code_o,
	output logic      [31:0] param_read_status_o,
	output logic             activated_o,
	// Parameter request channel.
	output logic             prd_req_o,
	output logic      [31:0] prd_addr_o,
	input  wire logic        prd_ack_i,
	input  wire logic        prd_ok_i,
	input  wire logic [1:0]  prd_type_i,
	input  wire logic [11:0] prd_fault_i
);

	////////////////////////////////////////////////////////////////////////////////
	// Declarations.
	logic [7:0]  cnt_q, cnt_d;
	logic        tick_q, tick_d;
	logic [31:0] ctrl_q, ctrl_d;
	logic [31:0] laddr_q, laddr_d;
	logic [31:0] rdata_q, rdata_d;
	logic [1:0]  rise;
	logic        enable;
	logic        fault;
	logic        ready;
	ifc_pkg::ifc_type_t  sel_req;
	ifc_pkg::ifc_type_t  sel_q, sel_d;
	ifc_pkg::ifc_state_t state_q, state_d;
	logic [15:0] cw_q, cw_d;
	logic        done_q, done_d;
	logic        err_q, err_d;
	logic [31:0] code_q, code_d;
	logic        act_q, act_d;
	logic        prd_start;
	logic        prd_abort;
	logic        prd_valid;
	logic        prd_ok;
	logic [1:0]  prd_type;
	logic [31:0] prd_stat;
	logic [31:0] prd_stat_q;
	logic        prd_req;
	logic [31:0] prd_addr;

	// Manual selector codes that need no detection.
	function automatic logic is_manual(input logic [2:0] t);
		is_manual = (t == ifc_pkg::type_active) || (t == ifc_pkg::type_smart) ||
			(t == ifc_pkg::type_basic);
	endfunction

	assign enable  = ctrl_q[ifc_pkg::CTRL_EN_BIT];
	assign sel_req = ifc_pkg::ifc_type_t'(ctrl_q[ifc_pkg::CTRL_TYPE_LSB +: 3]);
	assign fault   = status_word_i[ifc_pkg::SW_FAULT_BIT];
	assign ready   = status_word_i[ifc_pkg::SW_READY_BIT];

	////////////////////////////////////////////////////////////////////////////////
	// Program cycle divider: one tick pulse every program cycle.
	always_comb begin
		tick_d = (cnt_q == ifc_pkg::PROG_CYCLE_CLKS - 8'h01);
		cnt_d  = tick_d ? 8'h00 : cnt_q + 8'h01;
	end

	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			cnt_q  <= 8'h00;
			tick_q <= 1'b0;
		end else begin
			cnt_q  <= cnt_d;
			tick_q <= tick_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Register port: writes store, reads answer in the next cycle only.
	always_comb begin
		ctrl_d  = ctrl_q;
		laddr_d = laddr_q;
		rdata_d = 32'h0000_0000;
		if (wr_i && addr_i == ifc_pkg::REG_CTRL) begin
			ctrl_d = {25'h000_0000, wdata_i[6:4], 2'h0, wdata_i[1:0]};
		end
		if (wr_i && addr_i == ifc_pkg::REG_ADDR) begin
			laddr_d = wdata_i;
		end
		if (rd_i) begin
			unique case (addr_i)
				ifc_pkg::REG_CTRL:  rdata_d = ctrl_q;
				ifc_pkg::REG_ADDR:  rdata_d = laddr_q;
				ifc_pkg::REG_STAT:  rdata_d = {22'h00_0000, state_q, 1'b0, sel_q, 1'b0,
					act_q, err_q, done_q};
				ifc_pkg::REG_ERRC:  rdata_d = code_q;
				ifc_pkg::REG_PRDS:  rdata_d = prd_stat_q;
				ifc_pkg::REG_WORDS: rdata_d = {cw_q, status_word_i};
				default:            rdata_d = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			ctrl_q  <= ifc_pkg::CTRL_RESET;
			laddr_q <= ifc_pkg::ADDR_RESET;
			rdata_q <= 32'h0000_0000;
		end else begin
			ctrl_q  <= ctrl_d;
			laddr_q <= laddr_d;
			rdata_q <= rdata_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Edge detection on enable and reset, once per program cycle.
	ifc_edge u_edge (
		.mclk_i   (mclk_i),
		.resetn_i (resetn_i),
		.tick_i   (tick_q),
		.level_i  ({ctrl_q[ifc_pkg::CTRL_RST_BIT], enable}),
		.rise_o   (rise)
	);

	// Internal parameter-read function for automatic detection.
	ifc_prd u_prd (
		.mclk_i      (mclk_i),
		.resetn_i    (resetn_i),
		.start_i     (prd_start),
		.abort_i     (prd_abort),
		.addr_i      (laddr_q),
		.res_valid_o (prd_valid),
		.res_ok_o    (prd_ok),
		.res_type_o  (prd_type),
		.status_o    (prd_stat),
		.prd_req_o   (prd_req),
		.prd_addr_o  (prd_addr),
		.prd_ack_i   (prd_ack_i),
		.prd_ok_i    (prd_ok_i),
		.prd_type_i  (prd_type_i),
		.prd_fault_i (prd_fault_i)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Sequencer: acknowledge first, then switch handling, evaluated each tick.
	always_comb begin
		logic on_v;
		logic ack_v;
		logic err_v;
		logic [31:0] code_v;
		on_v      = cw_q[ifc_pkg::CW_ON_BIT];
		ack_v     = cw_q[ifc_pkg::CW_ACK_BIT];
		err_v     = err_q;
		code_v    = code_q;
		state_d   = state_q;
		sel_d     = sel_q;
		done_d    = done_q;
		act_d     = act_q;
		prd_start = 1'b0;
		prd_abort = 1'b0;
		if (tick_q) begin
			done_d = 1'b0;
			ack_v  = 1'b0;
			if (rise[ifc_pkg::EDGE_RST]) begin
				ack_v = 1'b1;
				if (fault) begin
					err_v  = 1'b1;
					code_v = ifc_pkg::ERR_INFEED_FAULT;
				end else begin
					err_v  = 1'b0;
					code_v = ifc_pkg::ERR_NONE;
				end
			end
			if (!enable) begin
				state_d   = ifc_pkg::st_off;
				on_v      = 1'b0;
				act_d     = 1'b0;
				prd_abort = 1'b1;
			end else begin
				unique case (state_q)
					ifc_pkg::st_off: begin
						if (rise[ifc_pkg::EDGE_EN] && !err_v) begin
							sel_d = sel_req;
							if (is_manual(sel_req)) begin
								state_d = ifc_pkg::st_start;
								on_v    = 1'b1;
							end else if (sel_req == ifc_pkg::type_auto) begin
								state_d   = ifc_pkg::st_detect;
								prd_start = 1'b1;
							end else begin
								sel_d  = ifc_pkg::type_undefined;
								err_v  = 1'b1;
								code_v = ifc_pkg::ERR_NO_TYPE;
							end
						end
					end
					ifc_pkg::st_detect: begin
						if (prd_valid && prd_ok) begin
							sel_d   = ifc_pkg::ifc_type_t'({1'b0, prd_type});
							state_d = ifc_pkg::st_start;
							on_v    = 1'b1;
						end else if (prd_valid) begin
							sel_d   = ifc_pkg::type_undefined;
							state_d = ifc_pkg::st_off;
							err_v   = 1'b1;
							code_v  = ifc_pkg::ERR_PRD;
						end
					end
					ifc_pkg::st_start: begin
						if (ready) begin
							state_d = ifc_pkg::st_on;
							act_d   = 1'b1;
							done_d  = 1'b1;
						end
					end
					ifc_pkg::st_on: begin
						// Selector changes are ignored here.
						sel_d = sel_q;
					end
				endcase
				if (fault && state_d != ifc_pkg::st_off) begin
					state_d = ifc_pkg::st_off;
					on_v    = 1'b0;
					act_d   = 1'b0;
					done_d  = 1'b0;
					err_v   = 1'b1;
					code_v  = ifc_pkg::ERR_INFEED_FAULT;
				end
			end
		end
		err_d  = err_v;
		code_d = code_v;
		cw_d   = ifc_pkg::CW_RESET;
		cw_d[ifc_pkg::CW_ON_BIT]  = on_v;
		cw_d[ifc_pkg::CW_ACK_BIT] = ack_v;
	end

	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state_q    <= ifc_pkg::st_off;
			sel_q      <= ifc_pkg::type_undefined;
			cw_q       <= ifc_pkg::CW_RESET;
			done_q     <= 1'b0;
			err_q      <= 1'b0;
			code_q     <= ifc_pkg::ERR_NONE;
			act_q      <= 1'b0;
			prd_stat_q <= ifc_pkg::PRD_IDLE;
		end else begin
			state_q    <= state_d;
			sel_q      <= sel_d;
			cw_q       <= cw_d;
			done_q     <= done_d;
			err_q      <= err_d;
			code_q     <= code_d;
			act_q      <= act_d;
			prd_stat_q <= prd_stat;
		end
	end

	// Output drive, all from registers.
	assign rdata_o             = rdata_q;
	assign control_word_out_o  = cw_q;
	assign done_o              = done_q;
	assign error_o             = err_q;
	assign error_code_o        = code_q;
	assign param_read_status_o = prd_stat_q;
	assign activated_o         = act_q;
	assign prd_req_o           = prd_req;
	assign prd_addr_o          = prd_addr;

	////////////////////////////////////////////////////////////////////////////////
	// Checks and coverage.
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!resetn_i);

	AST_OFF_WHEN_DISABLED: assert property (tick_q && !enable |=>
		!control_word_out_o[ifc_pkg::CW_ON_BIT] && !activated_o)
		else $error("infeed still on after enable low");
	AST_DONE_ONE_CYCLE: assert property (tick_q && done_o |=> !done_o)
		else $error("done held longer than one program cycle");
	AST_ERR_BLOCKS_ON: assert property (tick_q && rise[ifc_pkg::EDGE_EN] && error_o &&
		!rise[ifc_pkg::EDGE_RST] |=> !control_word_out_o[ifc_pkg::CW_ON_BIT])
		else $error("switch-on despite pending error");
	AST_ACK_CLEARS: assert property (tick_q && rise[ifc_pkg::EDGE_RST] && !enable &&
		!fault |=> !error_o && error_code_o == ifc_pkg::ERR_NONE)
		else $error("clean acknowledge did not clear error");
	AST_ACK_THEN_ON: assert property (tick_q && rise[ifc_pkg::EDGE_EN] &&
		rise[ifc_pkg::EDGE_RST] && !fault && is_manual(sel_req) |=>
		control_word_out_o[ifc_pkg::CW_ON_BIT] && !error_o)
		else $error("joint reset and enable did not switch on");
	AST_ACT_IMPLIES_ON: assert property (activated_o |->
		control_word_out_o[ifc_pkg::CW_ON_BIT] && state_q == ifc_pkg::st_on)
		else $error("activated without switch-on command");
	AST_TYPE_HELD: assert property (state_q == ifc_pkg::st_on && $past(state_q) ==
		ifc_pkg::st_on |-> $stable(sel_q))
		else $error("type changed while switched on");
	AST_STEADY_RESET: assert property (tick_q && error_o && !rise[ifc_pkg::EDGE_RST] |=>
		error_o)
		else $error("error cleared without reset edge");
	AST_CODE_ZERO: assert property (!error_o |-> error_code_o == ifc_pkg::ERR_NONE)
		else $error("error code set while no error");
	AST_AUTO_REQ: assert property (tick_q && state_q == ifc_pkg::st_off && enable &&
		rise[ifc_pkg::EDGE_EN] && !error_o && !rise[ifc_pkg::EDGE_RST] &&
		sel_req == ifc_pkg::type_auto |-> ##1 prd_req_o ##0 prd_addr_o == $past(laddr_q))
		else $error("automatic detection issued no parameter request");
	AST_MANUAL_NO_REQ: assert property (tick_q && rise[ifc_pkg::EDGE_EN] &&
		is_manual(sel_req) |=> !prd_req_o)
		else $error("parameter request under manual selection");

	COV_MANUAL_ON: cover property (tick_q && rise[ifc_pkg::EDGE_EN] && is_manual(sel_req)
		##[1:1000] done_o);
	COV_AUTO_ON: cover property (prd_req_o ##[1:1000] state_q == ifc_pkg::st_start);
	COV_ACK_ERR: cover property (tick_q && rise[ifc_pkg::EDGE_RST] && error_o);

endmodule

// ===== ifc_infeed_model.sv
// Behavioural infeed partner: status word and parameter-read answers.
`timescale 1ns/1ns
module ifc_infeed_model (
	// Clock and reset.
	input  wire logic        mclk_i,
	input  wire logic        resetn_i,
	// Cyclic words.
	input  wire logic [15:0] control_word_i,
	output logic      [15:0] status_word_o,
	// Parameter request channel.
	input  wire logic        prd_req_i,
	output logic             prd_ack_o,
	output logic             prd_ok_o,
	output logic      [1:0]  prd_type_o,
	output logic      [11:0] prd_fault_o,
	// Commands from the bench.
	input  wire logic        fault_i,
	input  wire logic        slow_i,
	input  wire logic        ans_ok_i,
	input  wire logic [1:0]  ans_type_i,
	input  wire logic [11:0] ans_fault_i
);
	logic [7:0] rdy_q;
	logic [7:0] ack_q;

	////////////////////////////////////////////////////////////////////////////////
	// Ready rises some clocks after the switch-on command; an answer follows a request.
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rdy_q <= 8'h00;
			ack_q <= 8'h00;
		end else begin
			rdy_q <= !control_word_i[0] ? 8'h00 : (rdy_q == 8'h14 ? rdy_q : rdy_q + 8'h01);
			if (prd_req_i) begin
				ack_q <= slow_i ? 8'h28 : 8'h03;
			end else if (ack_q != 8'h00) begin
				ack_q <= ack_q - 8'h01;
			end
		end
	end

	// Answer fields are only meaningful with the ack; otherwise they show the inverse.
	assign status_word_o = {12'h000, fault_i, 2'b00, rdy_q == 8'h14};
	assign prd_ack_o     = (ack_q == 8'h01);
	assign prd_ok_o      = prd_ack_o ? ans_ok_i : ~ans_ok_i;
	assign prd_type_o    = prd_ack_o ? ans_type_i : ~ans_type_i;
	assign prd_fault_o   = prd_ack_o ? ans_fault_i : ~ans_fault_i;
endmodule

// ===== ifc_infeed_ctrl_tb_top.sv
// Self-checking bench for the infeed on/off controller.
`timescale 1ns/1ns
module ifc_infeed_ctrl_tb_top;
	typedef struct {
		logic [2:0]  sel;
		logic        err;
		logic [31:0] code;
	} ifc_row_t;

	// Stimulus and partner commands, all set at time zero.
	logic        mclk_i   = 1'b0;
	logic        resetn_i = 1'b0;
	logic [7:0]  addr_i   = 8'h00;
	logic [31:0] wdata_i  = 32'h0000_0000;
	logic        wr_i     = 1'b0;
	logic        rd_i     = 1'b0;
	logic        fault    = 1'b0;
	logic        slow     = 1'b0;
	logic        ans_ok   = 1'b1;
	// Observed lines.
	logic [31:0] rdata_o, error_code_o, param_read_status_o, prd_addr_o, rv;
	logic [15:0] status_word_i, control_word_out_o;
	logic        done_o, error_o, activated_o, prd_req_o, prd_ack, prd_ok;
	logic [1:0]  prd_type;
	logic [11:0] prd_fault;
	int          bad_count = 0;
	int          checked   = 0;
	int          run       = 0;
	ifc_row_t    rows [4]  = '{'{3'h1, 1'b0, 32'h0}, '{3'h2, 1'b0, 32'h0},
		'{3'h3, 1'b0, 32'h0}, '{3'h0, 1'b1, ifc_pkg::ERR_NO_TYPE}};

	always #2 mclk_i = ~mclk_i;

	////////////////////////////////////////////////////////////////////////////////
	// Design and partner.
	ifc_infeed_ctrl ifc_infeed_ctrl_inst (.mclk_i(mclk_i), .resetn_i(resetn_i),
		.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
		.status_word_i(status_word_i), .control_word_out_o(control_word_out_o),
		.done_o(done_o), .error_o(error_o), .error_code_o(error_code_o),
		.param_read_status_o(param_read_status_o), .activated_o(activated_o),
		.prd_req_o(prd_req_o), .prd_addr_o(prd_addr_o), .prd_ack_i(prd_ack),
		.prd_ok_i(prd_ok), .prd_type_i(prd_type), .prd_fault_i(prd_fault));
	ifc_infeed_model ifc_infeed_model_inst (.mclk_i(mclk_i), .resetn_i(resetn_i),
		.control_word_i(control_word_out_o), .status_word_o(status_word_i),
		.prd_req_i(prd_req_o), .prd_ack_o(prd_ack), .prd_ok_o(prd_ok),
		.prd_type_o(prd_type), .prd_fault_o(prd_fault), .fault_i(fault), .slow_i(slow),
		.ans_ok_i(ans_ok), .ans_type_i(2'h2), .ans_fault_i(12'h0ab));

	////////////////////////////////////////////////////////////////////////////////
	// Counts one comparison and reports a mismatch.
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value at %0t: %s got %h", $time, msg, got);
		end
	endtask

	// Register bus write and read; read data stand in the cycle after the strobe.
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge mclk_i);
		addr_i  <= a;
		wdata_i <= v;
		wr_i    <= 1'b1;
		@(posedge mclk_i);
		wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge mclk_i);
		addr_i <= a;
		rd_i   <= 1'b1;
		@(posedge mclk_i);
		rd_i <= 1'b0;
		#1 rv = rdata_o;
	endtask

	// Control write followed by three program cycles.
	task automatic setc(input logic [31:0] v);
		wr(ifc_pkg::REG_CTRL, v);
		repeat (3 * int'(ifc_pkg::PROG_CYCLE_CLKS)) @(posedge mclk_i);
		#1;
	endtask
	task automatic expo(input logic e, input logic [31:0] c, input logic a, input string m);
		chk(error_o, e, m);
		chk(error_code_o, c, m);
		chk(activated_o, a, m);
		chk(control_word_out_o[0], a, m);
	endtask
	task report_and_stop;
		$display("comparisons %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// Measures the width of every done pulse.
	always @(posedge mclk_i) begin
		if (done_o === 1'b1) begin
			run++;
		end else if (run != 0) begin
			chk(32'(run), 32'(ifc_pkg::PROG_CYCLE_CLKS), "done width");
			run = 0;
		end
	end

	// Cuts a hang short.
	initial begin
		#360000;
		bad_count++;
		report_and_stop;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence.
	initial begin
		repeat (16) @(posedge mclk_i);
		resetn_i <= 1'b1;
		@(posedge mclk_i);
		#1 expo(1'b0, 32'h0, 1'b0, "reset outputs");
		rd(ifc_pkg::REG_CTRL);
		chk(rv, ifc_pkg::CTRL_RESET, "ctrl reset");
		rd(8'h20);
		chk(rv, 32'h0, "unmapped read");
		$display("test reset done");
		for (int i = 0; i < 4; i++) begin
			setc(32'h2);
			setc(32'h0);
			setc({25'h0, rows[i].sel, 4'h1});
			expo(rows[i].err, rows[i].code, !rows[i].err, "type row");
			rd(ifc_pkg::REG_STAT);
			chk(32'(rv[6:4]), 32'(rows[i].sel), "selected type");
			$display("test row %0d done", i);
		end
		setc(32'h0);
		setc(32'h2);
		setc(32'h0);
		setc(32'h3);
		expo(1'b1, ifc_pkg::ERR_NO_TYPE, 1'b0, "undefined type");
		setc(32'h2);
		setc(32'h13);
		expo(1'b1, ifc_pkg::ERR_NO_TYPE, 1'b0, "steady reset");
		setc(32'h10);
		setc(32'h13);
		expo(1'b0, 32'h0, 1'b1, "joint rise");
		setc(32'h33);
		rd(ifc_pkg::REG_STAT);
		chk(32'(rv[6:4]), 32'h1, "type while on");
		$display("test acknowledge done");
		@(posedge mclk_i);
		fault <= 1'b1;
		setc(32'h31);
		expo(1'b1, ifc_pkg::ERR_INFEED_FAULT, 1'b0, "infeed fault");
		setc(32'h33);
		expo(1'b1, ifc_pkg::ERR_INFEED_FAULT, 1'b0, "fault remains");
		rd(ifc_pkg::REG_WORDS);
		chk(rv, 32'h0000_0008, "cyclic words");
		fault <= 1'b0;
		setc(32'h31);
		setc(32'h33);
		expo(1'b0, 32'h0, 1'b0, "fault cleared");
		setc(32'h30);
		setc(32'h31);
		rd(ifc_pkg::REG_STAT);
		chk(32'(rv[6:4]), 32'h3, "new type");
		setc(32'h30);
		expo(1'b0, 32'h0, 1'b0, "switch off");
		$display("test fault done");
		wr(ifc_pkg::REG_ADDR, 32'h0000_1234);
		setc(32'h41);
		expo(1'b0, 32'h0, 1'b1, "auto detect");
		chk(prd_addr_o, 32'h0000_1234, "request address");
		chk(param_read_status_o, ifc_pkg::PRD_IDLE, "read status");
		rd(ifc_pkg::REG_STAT);
		chk(32'(rv[6:4]), 32'h2, "detected type");
		setc(32'h40);
		slow   <= 1'b1;
		ans_ok <= 1'b0;
		setc(32'h41);
		expo(1'b1, ifc_pkg::ERR_PRD, 1'b0, "read failure");
		chk(param_read_status_o, ifc_pkg::PRD_ERR_BASE | 32'h0ab, "fail status");
		rd(ifc_pkg::REG_ERRC);
		chk(rv, ifc_pkg::ERR_PRD, "error register");
		@(posedge mclk_i);
		#1 chk(rdata_o, 32'h0, "read data one cycle only");
		$display("test auto detect done");
		// Reset in mid-run clears a pending error; a reset rise then raises the acknowledge bit.
		@(posedge mclk_i);
		resetn_i <= 1'b0;
		repeat (16) @(posedge mclk_i);
		resetn_i <= 1'b1;
		@(posedge mclk_i);
		#1 expo(1'b0, 32'h0, 1'b0, "mid-run reset");
		chk(32'(done_o), 32'h0, "done after reset");
		chk(param_read_status_o, ifc_pkg::PRD_IDLE, "read status after reset");
		wr(ifc_pkg::REG_CTRL, 32'h2);
		for (int n = 0; n < 2 * int'(ifc_pkg::PROG_CYCLE_CLKS); n++) begin
			if (control_word_out_o[ifc_pkg::CW_ACK_BIT] === 1'b1) begin
				break;
			end
			@(posedge mclk_i);
		end
		#1 chk(32'(control_word_out_o[ifc_pkg::CW_ACK_BIT]), 32'h1, "acknowledge bit");
		setc(32'h11);
		expo(1'b0, 32'h0, 1'b1, "on after reset");
		$display("test mid-run reset done");
		report_and_stop;
	end
endmodule
